// ---- hdl/ssmc_top.sv ----
// Module: sensor monitor register bank on Avalon-MM with sequencing and readback
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module ssmc_top
  import ssmc_pkg::*;
(
  input wire logic clk_in,                     // 200 MHz clock
  input wire logic rst_in,                     // Synchronous reset, active high
  input wire logic [11:0] avs_address_in,      // Byte address
  input wire logic avs_read_in,                // Read request
  input wire logic avs_write_in,               // Write request
  input wire logic [31:0] avs_writedata_in,    // Write data
  input wire logic [3:0] avs_byteenable_in,    // Byte lanes
  output logic [31:0] avs_readdata_out,        // Read data
  output logic avs_waitrequest_out,            // Stall
  input wire logic link_up_in,                 // Media link is up
  input wire logic harsh_mode_in,              // Harsh industrial mode
  input wire logic adc_sample_valid_in,        // ADC sample strobe
  input wire logic [15:0] adc_sample_in,       // ADC sample
  output logic adc_enable_out,                 // ADC running
  output logic [2:0] adc_sensor_select_out,    // Sensor fed to the ADC
  output logic [2:0] adc_decimation_out,       // Decimation for current phase
  output logic [1:0] monitor_phase_out,        // Current monitor phase
  output logic sensor_hold_reset_out,          // Sensor held in reset
  output logic gain_from_registers_out,        // Gains from registers
  output logic ecc_protect_enable_out,         // ECC and checksum on
  output logic ecc_inject_error_out,           // Corrupt protected bank
  output logic [2:0] lock_window_setting_out,  // Lock detect window
  output logic [1:0] lock_wait_setting_out,    // Lock detect wait
  output logic lock_monitor_enable_out         // Lock monitor enable
);

  // -----------------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] start_ctl;         // Force start control
    logic [15:0] seldec;            // Select and decimation
    logic [15:0] seqcfg;            // Sequence configuration
    logic [15:0] lockecc;           // Lock detect and ECC control
    logic [15:0] sample_hold;       // Last ADC sample
    logic [4:0][15:0] store;        // Last sample per sensor
    logic [15:0] readback;          // Readback register
    logic [31:0] rdata;             // Bus read data
    logic waitreq;                  // Bus stall
    logic adc_en;                   // ADC running
    logic [2:0] dec;                // Active decimation
    logic hold_rst;                 // Sensor reset
    logic ecc_prot;                 // ECC enable as seen
    logic ecc_inj;                  // Error injection
  } ssmc_top_s;

  ssmc_top_s s_r;
  ssmc_top_s s_nxt;

  ssmc_seq_if seq_bus ();

  logic [9:0] idx;                  // Word index of the access
  assign idx = avs_address_in[11:2];

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~m) | (wd[15:0] & m);
  endfunction : merge

  // -----------------------------------------------------------------------------
  // Sequencer configuration, taken straight from the register copies and, for run, the link input
  // -----------------------------------------------------------------------------
  // Monitors run once the link is up, or at once when forced
  assign seq_bus.run = link_up_in || s_r.start_ctl[SSMC_FORCE_BIT]; // see [R13]
  assign seq_bus.bypass = s_r.seqcfg[SSMC_BYPASS_BIT]; // see [R07]
  assign seq_bus.iter_count = s_r.seqcfg[SSMC_ITER_LSB +: 2]; // see [R08]
  assign seq_bus.slots = s_r.seqcfg[SSMC_SLOTS_LSB +: 12]; // see [R09]
  assign seq_bus.bypass_sel = s_r.seldec[SSMC_BYPSEL_LSB +: 3]; // see [R05]

  // Sequencer instance
  ssmc_sequencer u_seq (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sample_valid_in(adc_sample_valid_in),
    .bus(seq_bus.seq)
  );

  // -----------------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------------
  always_comb begin
    logic [2:0] rsel;
    rsel = s_r.seldec[SSMC_RDSEL_LSB +: 3];
    s_nxt = s_r;

    // Catch the sample at its strobe; the store strobe comes a cycle later
    if (adc_sample_valid_in) begin
      s_nxt.sample_hold = adc_sample_in;
    end
    if (seq_bus.store && seq_bus.store_idx < SSMC_NUM_SENSORS) begin // see [R10]
      s_nxt.store[seq_bus.store_idx] = s_r.sample_hold;
    end

    // Readback follows the selected sensor; reserved codes read zero
    if (rsel < SSMC_NUM_SENSORS) begin // see [R01]
      s_nxt.readback = s_r.store[rsel]; // see [R10]
    end else begin
      s_nxt.readback = 16'h0000;
    end

    // Decimation tracks the monitor phase
    case (seq_bus.phase)
      SSMC_PH_GAIN_CAL: begin
        s_nxt.dec = s_r.seldec[SSMC_GAINDEC_LSB +: 3]; // see [R03]
      end
      SSMC_PH_OFFSET_CAL: begin
        s_nxt.dec = s_r.seldec[SSMC_OFFSDEC_LSB +: 3]; // see [R04]
      end
      default: begin
        s_nxt.dec = s_r.seldec[SSMC_NORMDEC_LSB +: 3]; // see [R02]
      end
    endcase
    s_nxt.adc_en = (seq_bus.phase != SSMC_PH_IDLE);

    // Bypass hands the sensor reset to software; otherwise it follows run
    if (seq_bus.bypass) begin
      s_nxt.hold_rst = ~s_r.seldec[SSMC_BYPRST_BIT]; // see [R14]
    end else begin
      s_nxt.hold_rst = ~seq_bus.run;
    end

    // Protection only exists in harsh industrial mode
    s_nxt.ecc_prot = harsh_mode_in && s_r.lockecc[SSMC_ECCEN_BIT]; // see [R11]
    s_nxt.ecc_inj = harsh_mode_in && s_r.lockecc[SSMC_ECCEN_BIT]
                    && s_r.lockecc[SSMC_ECCERR_BIT]; // see [R12]

    // Bus: first cycle of a request drops the stall and prepares read data
    s_nxt.waitreq = 1'b1;
    if ((avs_read_in || avs_write_in) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      case (idx)
        SSMC_IDX_START: begin
          s_nxt.rdata = {16'h0000, s_r.start_ctl};
        end
        SSMC_IDX_SELDEC: begin
          s_nxt.rdata = {16'h0000, s_r.seldec};
        end
        SSMC_IDX_SEQCFG: begin
          s_nxt.rdata = {16'h0000, s_r.seqcfg};
        end
        SSMC_IDX_RDBACK: begin
          s_nxt.rdata = {16'h0000, s_r.readback}; // see [R10]
        end
        SSMC_IDX_LOCKECC: begin
          s_nxt.rdata = {16'h0000, s_r.lockecc}; // see [R15]
        end
        default: begin
          // Unmapped words read as zero
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Second cycle: the write lands on the edge that sees the stall low
    if (avs_write_in && !s_r.waitreq) begin
      case (idx)
        SSMC_IDX_START: begin
          s_nxt.start_ctl = merge(s_r.start_ctl, avs_writedata_in, avs_byteenable_in,
                                  SSMC_MASK_START);
        end
        SSMC_IDX_SELDEC: begin
          s_nxt.seldec = merge(s_r.seldec, avs_writedata_in, avs_byteenable_in,
                               SSMC_MASK_ALL);
        end
        SSMC_IDX_SEQCFG: begin
          s_nxt.seqcfg = merge(s_r.seqcfg, avs_writedata_in, avs_byteenable_in,
                               SSMC_MASK_ALL);
        end
        SSMC_IDX_LOCKECC: begin
          s_nxt.lockecc = merge(s_r.lockecc, avs_writedata_in, avs_byteenable_in,
                                SSMC_MASK_ALL); // see [R15]
        end
        default: begin
          // Readback and unmapped words ignore writes
          s_nxt.start_ctl = s_r.start_ctl;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r.start_ctl <= SSMC_RST_START;
      s_r.seldec <= SSMC_RST_SELDEC;
      s_r.seqcfg <= SSMC_RST_SEQCFG;
      s_r.lockecc <= SSMC_RST_LOCKECC;
      s_r.sample_hold <= 16'h0000;
      s_r.store <= '0;
      s_r.readback <= SSMC_RST_RDBACK;
      s_r.rdata <= 32'h0000_0000;
      s_r.waitreq <= 1'b1;
      s_r.adc_en <= 1'b0;
      s_r.dec <= 3'h0;
      s_r.hold_rst <= 1'b1;
      s_r.ecc_prot <= 1'b0;
      s_r.ecc_inj <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // -----------------------------------------------------------------------------
  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = s_r.waitreq;
  assign adc_enable_out = s_r.adc_en;
  assign adc_sensor_select_out = seq_bus.sensor;
  assign adc_decimation_out = s_r.dec;
  assign monitor_phase_out = seq_bus.phase;
  assign sensor_hold_reset_out = s_r.hold_rst;
  assign gain_from_registers_out = s_r.seqcfg[SSMC_GAINSRC_BIT]; // see [R06]
  assign ecc_protect_enable_out = s_r.ecc_prot;
  assign ecc_inject_error_out = s_r.ecc_inj;
  assign lock_window_setting_out = s_r.lockecc[SSMC_WINDOW_LSB +: 3]; // see [R15]
  assign lock_wait_setting_out = s_r.lockecc[SSMC_WAIT_LSB +: 2];
  assign lock_monitor_enable_out = s_r.lockecc[SSMC_LOCKMON_BIT];

endmodule : ssmc_top

// ---- hdl/ssmc_pkg.sv ----
// Package: register map, field layout, reset values and sequencer types of the sensor monitor
// -----------------------------------------------------------------------------
// Overview of operation
// [R01] Readback selector picks sensor 0-4, 5-7 reserved
// [R02] Normal-mode decimation field, reset value 4
// [R03] Gain-calibration decimation field, reset value 4
// [R04] Offset-calibration decimation field, reset value 4
// [R05] Bypass selector picks the monitored sensor, reset 0
// [R06] Gain source: fuses when clear, registers when set
// [R07] Bypass bit hands sensors to manual selection
// [R08] Iteration count: slot passes before full sweep
// [R09] Four slot selectors; resets 5,5,5,1
// [R10] Read-only 16-bit readback of sensor data
// [R11] ECC enable, harsh industrial mode only
// [R12] Error-inject bit corrupts protected bank while enabled
// [R13] Monitors start on link up or force start
// [R14] Bypass reset control: 0 holds, 1 releases sensor
// [R15] Lock-detect fields kept as plain configuration
// -----------------------------------------------------------------------------
package ssmc_pkg;

  // -----------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -----------------------------------------------------------------------------
  localparam logic [9:0] SSMC_IDX_START = 10'h1E2;   // Monitor start control
  localparam logic [9:0] SSMC_IDX_SELDEC = 10'h1E8;  // Select and decimation
  localparam logic [9:0] SSMC_IDX_SEQCFG = 10'h1E9;  // Sequence configuration
  localparam logic [9:0] SSMC_IDX_RDBACK = 10'h1EA;  // Readback data
  localparam logic [9:0] SSMC_IDX_LOCKECC = 10'h1EE; // Lock detect and ECC control

  // Reset values and writable bits
  localparam logic [15:0] SSMC_RST_START = 16'h0000;
  localparam logic [15:0] SSMC_MASK_START = 16'h0002;
  localparam logic [15:0] SSMC_RST_SELDEC = 16'h0920;
  localparam logic [15:0] SSMC_RST_SEQCFG = 16'h036D;
  localparam logic [15:0] SSMC_RST_LOCKECC = 16'h0035;
  localparam logic [15:0] SSMC_RST_RDBACK = 16'h0000;
  localparam logic [15:0] SSMC_MASK_ALL = 16'hFFFF;

  // Field positions
  localparam int SSMC_FORCE_BIT = 1;
  localparam int SSMC_BYPRST_BIT = 15;
  localparam int SSMC_RDSEL_LSB = 12;
  localparam int SSMC_NORMDEC_LSB = 9;
  localparam int SSMC_GAINDEC_LSB = 6;
  localparam int SSMC_OFFSDEC_LSB = 3;
  localparam int SSMC_BYPSEL_LSB = 0;
  localparam int SSMC_GAINSRC_BIT = 15;
  localparam int SSMC_BYPASS_BIT = 14;
  localparam int SSMC_ITER_LSB = 12;
  localparam int SSMC_SLOTS_LSB = 0;
  localparam int SSMC_ECCEN_BIT = 8;
  localparam int SSMC_ECCERR_BIT = 7;
  localparam int SSMC_WINDOW_LSB = 4;
  localparam int SSMC_WAIT_LSB = 2;
  localparam int SSMC_LOCKMON_BIT = 0;

  // Sensor codes 0..4 exist, the rest are reserved
  localparam logic [2:0] SSMC_NUM_SENSORS = 3'h5;
  localparam logic [2:0] SSMC_LAST_SENSOR = 3'h4;

  typedef logic [2:0] ssmc_sensor_t;

  // -----------------------------------------------------------------------------
  // Sequencer states and monitor phases
  // -----------------------------------------------------------------------------
  typedef enum logic [5:0] {
    SSMC_ST_IDLE = 6'h01,
    SSMC_ST_GAIN = 6'h02,
    SSMC_ST_OFFS = 6'h04,
    SSMC_ST_SLOTS = 6'h08,
    SSMC_ST_SWEEP = 6'h10,
    SSMC_ST_BYPASS = 6'h20
  } ssmc_state_e;

  typedef enum logic [1:0] {
    SSMC_PH_IDLE = 2'h0,
    SSMC_PH_GAIN_CAL = 2'h1,
    SSMC_PH_OFFSET_CAL = 2'h2,
    SSMC_PH_NORMAL = 2'h3
  } ssmc_phase_e;

endpackage : ssmc_pkg

// ---- hdl/ssmc_seq_if.sv ----
// Interface: configuration to the sensor sequencer and its selection and store strobe back
`timescale 1ns/1ps
interface ssmc_seq_if;
  import ssmc_pkg::*;
  logic run;                // Monitors allowed to operate
  logic bypass;             // Manual sensor selection
  logic [1:0] iter_count;   // Slot passes before a full sweep
  logic [11:0] slots;       // Four 3-bit slot sensor codes
  ssmc_sensor_t bypass_sel; // Sensor picked in bypass
  ssmc_sensor_t sensor;     // Sensor now fed to the ADC
  ssmc_phase_e phase;       // Calibration or normal phase
  logic store;              // Held sample belongs to store_idx
  ssmc_sensor_t store_idx;  // Sensor whose sample is stored

  modport ctrl (output run, bypass, iter_count, slots, bypass_sel,
                input sensor, phase, store, store_idx);
  modport seq (input run, bypass, iter_count, slots, bypass_sel,
               output sensor, phase, store, store_idx);
endinterface : ssmc_seq_if

// ---- hdl/ssmc_sequencer.sv ----
// Module: monitor sequencer walking calibration, iteration slots and full sensor sweeps
`timescale 1ns/1ps
module ssmc_sequencer
  import ssmc_pkg::*;
(
  input wire logic clk_in,          // 200 MHz clock
  input wire logic rst_in,          // Synchronous reset, active high
  input wire logic sample_valid_in, // ADC delivered a sample
  ssmc_seq_if.seq bus               // Configuration and results
);

  // -----------------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------------
  typedef struct packed {
    ssmc_state_e st;         // Sequencer state
    logic [1:0] slot;        // Current slot
    logic [1:0] iter;        // Completed slot passes
    ssmc_sensor_t sensor;    // Selected sensor
    ssmc_phase_e phase;      // Monitor phase
    logic store;             // Store strobe
    ssmc_sensor_t store_idx; // Store target
  } ssmc_seq_s;

  ssmc_seq_s s_r;
  ssmc_seq_s s_nxt;

  // Sensor code held in a given slot
  function automatic ssmc_sensor_t slot_code(input logic [11:0] slots, input logic [1:0] idx);
    slot_code = slots[idx*3 +: 3];
  endfunction : slot_code

  // -----------------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.store = 1'b0;
    s_nxt.store_idx = s_r.sensor;
    case (s_r.st)
      SSMC_ST_IDLE: begin
        s_nxt.phase = SSMC_PH_IDLE;
        if (bus.run) begin // see [R13]
          s_nxt.st = SSMC_ST_GAIN;
          s_nxt.phase = SSMC_PH_GAIN_CAL;
        end
      end
      SSMC_ST_GAIN: begin
        // One conversion per calibration stage
        if (sample_valid_in) begin
          s_nxt.st = SSMC_ST_OFFS;
          s_nxt.phase = SSMC_PH_OFFSET_CAL;
        end
      end
      SSMC_ST_OFFS, SSMC_ST_SWEEP: begin
        if (sample_valid_in) begin
          s_nxt.store = (s_r.st == SSMC_ST_SWEEP);
          s_nxt.phase = SSMC_PH_NORMAL;
          if (s_r.st == SSMC_ST_SWEEP && s_r.sensor != SSMC_LAST_SENSOR) begin
            s_nxt.sensor = s_r.sensor + 3'h1;
          end else if (bus.iter_count == 2'h0) begin // see [R08]
            // No slot passes: sweep all sensors again
            s_nxt.st = SSMC_ST_SWEEP;
            s_nxt.sensor = 3'h0;
          end else begin
            s_nxt.st = SSMC_ST_SLOTS;
            s_nxt.slot = 2'h0;
            s_nxt.iter = 2'h0;
            s_nxt.sensor = slot_code(bus.slots, 2'h0); // see [R09]
          end
        end
      end
      SSMC_ST_SLOTS: begin
        // Reserved slot codes are skipped without a conversion
        if (s_r.sensor >= SSMC_NUM_SENSORS || sample_valid_in) begin
          s_nxt.store = (s_r.sensor < SSMC_NUM_SENSORS);
          if (s_r.slot == 2'h3) begin
            s_nxt.slot = 2'h0;
            s_nxt.iter = s_r.iter + 2'h1;
            if (s_r.iter + 2'h1 == bus.iter_count) begin // see [R08]
              s_nxt.st = SSMC_ST_SWEEP;
              s_nxt.sensor = 3'h0;
            end else begin
              s_nxt.sensor = slot_code(bus.slots, 2'h0); // see [R09]
            end
          end else begin
            s_nxt.slot = s_r.slot + 2'h1;
            s_nxt.sensor = slot_code(bus.slots, s_r.slot + 2'h1); // see [R09]
          end
        end
      end
      SSMC_ST_BYPASS: begin
        // Manual selection tracks the field every cycle
        s_nxt.sensor = bus.bypass_sel; // see [R05]
        s_nxt.store = sample_valid_in && (s_r.sensor < SSMC_NUM_SENSORS);
      end
      default: begin
        s_nxt.st = SSMC_ST_IDLE;
      end
    endcase
    // Overrides: stop, enter bypass, leave bypass to recalibrate
    if (!bus.run) begin // see [R13]
      s_nxt.st = SSMC_ST_IDLE;
      s_nxt.phase = SSMC_PH_IDLE;
    end else if (bus.bypass && s_r.st != SSMC_ST_BYPASS) begin // see [R07]
      s_nxt.st = SSMC_ST_BYPASS;
      s_nxt.phase = SSMC_PH_NORMAL;
      s_nxt.sensor = bus.bypass_sel;
      s_nxt.store = 1'b0;
    end else if (!bus.bypass && s_r.st == SSMC_ST_BYPASS) begin // see [R07]
      s_nxt.st = SSMC_ST_IDLE;
      s_nxt.phase = SSMC_PH_IDLE;
    end
  end

  // -----------------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '{st: SSMC_ST_IDLE, slot: 2'h0, iter: 2'h0, sensor: 3'h0,
               phase: SSMC_PH_IDLE, store: 1'b0, store_idx: 3'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.sensor = s_r.sensor;
  assign bus.phase = s_r.phase;
  assign bus.store = s_r.store;
  assign bus.store_idx = s_r.store_idx;

endmodule : ssmc_sequencer

// ---- sim/ssmc_top_assertions.sv ----
// Checker: bus handshake, phase order and ECC output relations of the sensor monitor
`timescale 1ns/1ps
module ssmc_top_assertions
  import ssmc_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Sync reset
  input wire logic avs_read_in, // Bus read
  input wire logic avs_write_in, // Bus write
  input wire logic avs_waitrequest_out, // Bus stall
  input wire logic [31:0] avs_readdata_out, // Read data
  input wire logic harsh_mode_in, // Harsh mode
  input wire logic adc_sample_valid_in, // Sample strobe
  input wire logic adc_enable_out, // ADC running
  input wire logic [1:0] monitor_phase_out, // Monitor phase
  input wire logic ecc_protect_enable_out, // ECC on
  input wire logic ecc_inject_error_out // ECC inject
);
  // ---------------------------------------------------------------
  // Clock and reset given once
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Taken request answers after exactly one stall cycle
  a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("stall not one cycle");
  // Stall drop lasts a single cycle
  a_wait_single_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("stall low too long");
  // No answer without a request
  a_wait_idle_high: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("stall dropped idle");
  // Registers are 16 bits wide, upper half reads zero
  a_read_upper_zero: assert property (avs_read_in && !avs_waitrequest_out
    |-> avs_readdata_out[31:16] == 16'h0000) else $error("upper half set");
  // Protection only in harsh mode
  a_ecc_needs_harsh: assert property (!$past(harsh_mode_in) |-> !ecc_protect_enable_out)
    else $error("ECC outside harsh");
  // Injection only while protection is on
  a_inject_needs_ecc: assert property (ecc_inject_error_out |-> ecc_protect_enable_out)
    else $error("inject without ECC");
  // ADC runs one cycle behind any active phase
  a_adc_follows_phase: assert property (adc_enable_out == ($past(monitor_phase_out) != 2'h0))
    else $error("ADC enable wrong");
  // Offset calibration is entered only from gain calibration
  a_offset_after_gain: assert property (monitor_phase_out == 2'h2
    |-> $past(monitor_phase_out) inside {2'h1, 2'h2}) else $error("offset phase not after gain");
  // One sample ends gain calibration
  a_gain_leaves: assert property (monitor_phase_out == 2'h1 && adc_sample_valid_in
    |-> ##[1:2] monitor_phase_out != 2'h1) else $error("gain phase stuck");
  // Main scenarios reached
  c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
  c_write_done: cover property (avs_write_in && !avs_waitrequest_out);
  c_normal_phase: cover property (monitor_phase_out == 2'h3);
  c_inject: cover property (ecc_inject_error_out);
endmodule : ssmc_top_assertions

// ---- sim/ssmc_top_tb.sv ----
// Testbench: registers, readback, sequencer order and ECC controls of the sensor monitor
`timescale 1ns/1ps
module ssmc_top_tb;
  import ssmc_pkg::*;
  // ---------------------------------------------------------------
  // Design signals
  // ---------------------------------------------------------------
  logic clk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [11:0] avs_address_in = 12'h000;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [3:0] avs_byteenable_in = 4'h0;
  logic avs_waitrequest_out, link_up_in = 1'b0, harsh_mode_in = 1'b0, adc_sample_valid_in = 1'b0;
  logic [15:0] adc_sample_in = 16'h0000;
  logic adc_enable_out, sensor_hold_reset_out, gain_from_registers_out, ecc_protect_enable_out;
  logic ecc_inject_error_out, lock_monitor_enable_out;
  logic [2:0] adc_sensor_select_out, adc_decimation_out, lock_window_setting_out;
  logic [1:0] monitor_phase_out, lock_wait_setting_out;
  int num_errors = 0, comparisons = 0;
  logic [15:0] exp_q[$]; // Expected read data, oldest first
  // Index, writable bits, shadow; last unmapped
  logic [9:0] idx_t [6] = '{SSMC_IDX_START, SSMC_IDX_SELDEC, SSMC_IDX_SEQCFG, SSMC_IDX_RDBACK,
    SSMC_IDX_LOCKECC, 10'h100};
  logic [15:0] msk_t [6] = '{16'h0002, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000};
  logic [15:0] shd [6] = '{16'h0000, 16'h0920, 16'h036D, 16'h0000, 16'h0035, 16'h0000};
  // Slot sensors, then a sweep
  logic [2:0] seq_t [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};

  ssmc_top dut_u (.*);

  // Clock of 5 ns period
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One bus transfer, started after an edge
  task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d,
    input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= {16'($urandom), d}; // Junk upper half
    avs_byteenable_in <= b;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) check("waitrequest", 32'h0, 32'h1);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic wrr(input int i, input logic [15:0] d, input logic [3:0] b);
    logic [15:0] m;
    m = msk_t[i] & {{8{b[1]}}, {8{b[0]}}};
    shd[i] = (shd[i] & ~m) | (d & m);
    bus(1'b1, idx_t[i], d, b);
  endtask : wrr
  task automatic rdx(input int i);
    exp_q.push_back(shd[i]);
    bus(1'b0, idx_t[i], 16'h0000, 4'hF);
  endtask : rdx
  // ADC sample, then settle time
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_in);
    adc_sample_valid_in <= 1'b1;
    adc_sample_in <= v;
    @(posedge clk_in);
    adc_sample_valid_in <= 1'b0;
    adc_sample_in <= ~v; // Stale bus must not pass for the sample
    repeat (4) @(posedge clk_in);
  endtask : pulse
  task automatic report_and_stop();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Reads checked against oldest note
  always @(posedge clk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0) begin
      check("readdata", {16'h0000, exp_q.pop_front()}, avs_readdata_out);
    end
  end

  // Watchdog
  initial begin
    #(5 * 20000);
    num_errors++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    logic [15:0] v;
    void'($urandom(32'hE351));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) rdx(i);
    for (int k = 0; k < 16; k++) wrr($urandom_range(0, 5), 16'($urandom), 4'($urandom));
    for (int i = 0; i < 6; i++) rdx(i);
    check("window", shd[4][6:4], lock_window_setting_out);
    check("wait", shd[4][3:2], lock_wait_setting_out);
    check("lockmon", shd[4][0], lock_monitor_enable_out);
    check("gainsrc", shd[2][15], gain_from_registers_out);
    // ECC enable and inject in both modes
    for (int h = 0; h < 2; h++) begin
      for (int e = 0; e < 4; e++) begin
        harsh_mode_in <= h[0];
        wrr(4, {shd[4][15:9], e[1:0], shd[4][6:0]}, 4'h3);
        repeat (2) @(posedge clk_in);
        check("ecc_en", h[0] & e[1], ecc_protect_enable_out);
        check("ecc_inj", h[0] & e[1] & e[0], ecc_inject_error_out);
      end
    end
    // Bypass sensor 2, released, forced
    wrr(1, 16'hA922, 4'hF);
    wrr(2, 16'hC36D, 4'hF); // Bypass and registered gains
    wrr(0, 16'h0002, 4'hF);
    repeat (3) @(posedge clk_in);
    check("gainsrc", 1'b1, gain_from_registers_out);
    check("select", 3'h2, adc_sensor_select_out);
    check("hold", 1'b0, sensor_hold_reset_out);
    v = 16'($urandom);
    repeat (3) pulse(v);
    shd[3] = v;
    rdx(3);
    shd[3] = 16'h0000;
    wrr(1, 16'hB922, 4'hF);
    rdx(3);
    wrr(1, 16'hD922, 4'hF);
    rdx(3);
    wrr(1, 16'h5922, 4'hF);
    repeat (2) @(posedge clk_in);
    check("hold", 1'b1, sensor_hold_reset_out);
    // Second reset, then sequencer started by the link
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    wrr(1, 16'h0BB8, 4'hF);
    wrr(2, 16'h1688, 4'hF);
    repeat (4) @(posedge clk_in);
    check("phase", 2'h0, monitor_phase_out);
    link_up_in <= 1'b1;
    n = 0;
    while (monitor_phase_out !== 2'h1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    repeat (2) @(posedge clk_in);
    check("phase", 2'h1, monitor_phase_out);
    check("dec", 3'h6, adc_decimation_out);
    pulse(16'h1234);
    check("phase", 2'h2, monitor_phase_out);
    check("dec", 3'h7, adc_decimation_out);
    pulse(16'h1234);
    check("phase", 2'h3, monitor_phase_out);
    check("dec", 3'h5, adc_decimation_out);
    check("adc_en", 1'b1, adc_enable_out);
    foreach (seq_t[i]) begin
      check("slot", seq_t[i], adc_sensor_select_out);
      pulse(16'($urandom));
    end
    report_and_stop();
  end
endmodule : ssmc_top_tb

bind ssmc_top ssmc_top_assertions chk_u (.*);
